// File: src/spectral_status_flags.sv
`timescale 1ns/100ps
module spectral_status_flags
    import status_flags_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire reg_wr_t i_wr,
    input wire logic [7:0] i_rd_addr,
    output logic [7:0] o_rd_data,
    input wire meas_evt_t i_meas,
    input wire logic i_sync_start_mode,
    input wire logic i_sync_start_stop_mode,
    input wire logic i_spectral_irq_enable,
    input wire logic i_fifo_irq_enable,
    input wire logic i_system_irq_enable,
    input wire logic [3:0] i_persistence_count,
    input wire logic [15:0] i_th_low,
    input wire logic [15:0] i_th_high,
    input wire logic [7:0] i_fifo_fill_count,
    input wire logic [7:0] i_fifo_threshold,
    input wire logic i_calibration_event,
    input wire logic i_mux_command_done,
    output logic [7:0] o_event_status
);
    //////////////////////////////////////////////////////////////////////
    // registered flags with their next values, plus the event set and clear vectors
    logic ready_q, ready_d;
    logic wait_q, wait_d;
    logic [7:0] evt_q, evt_d;
    logic valid_q, valid_d;
    logic sat_q, sat_d;
    logic mux_q, mux_d;
    logic [7:0] rd_q, rd_d;
    logic thr_hit;
    logic [7:0] set_v;
    logic [7:0] clr_v;
    logic fifo_cond;

    // decodes a write strobe aimed at one register address
    function automatic logic wr_hit(input reg_wr_t w, input logic [7:0] a);
        wr_hit = w.en && (w.addr == a);
    endfunction : wr_hit

    // persistence counter; its hit lags the measurement by one more cycle
    threshold_persist u_thr (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_sample(i_meas.meas_done),
        .i_ch0(i_meas.ch0_result),
        .i_th_low(i_th_low),
        .i_th_high(i_th_high),
        .i_persistence_count(i_persistence_count),
        .o_hit(thr_hit)
    );

    //////////////////////////////////////////////////////////////////////
    // measurement state, second status and mux done flag
    always_comb
    begin
        ready_d = ready_q;
        if (i_meas.meas_start)
            ready_d = 1'b0;
        if (i_meas.meas_done)
            ready_d = 1'b1;
        wait_d = i_meas.sync_wait && (i_sync_start_mode || i_sync_start_stop_mode);
        valid_d = valid_q;
        if (i_meas.meas_start)
            valid_d = 1'b0;
        if (i_meas.meas_done)
            valid_d = 1'b1;
        sat_d = sat_q;
        if (i_meas.meas_start)
            sat_d = 1'b0;
        if (i_meas.peak_count >= i_meas.max_count)
            sat_d = 1'b1;
        // done flag is write-one-clear too; a new completion wins the clear
        mux_d = mux_q;
        if (wr_hit(i_wr, ADDR_MUX_STATUS) && i_wr.data[BIT_MUX_DONE])
            mux_d = 1'b0;
        if (i_mux_command_done)
            mux_d = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////
    // event status: sets ordered after clears so nothing is lost
    always_comb
    begin
        fifo_cond = (i_fifo_fill_count != 8'h00) && (i_fifo_fill_count >= i_fifo_threshold);
        set_v = RESET_BYTE;
        set_v[BIT_SPECTRAL] = i_spectral_irq_enable && thr_hit;
        set_v[BIT_FIFO] = i_fifo_irq_enable && fifo_cond;
        set_v[BIT_CALIB] = i_calibration_event;
        set_v[BIT_SYSTEM] = i_system_irq_enable && mux_q;
        clr_v = wr_hit(i_wr, ADDR_EVENT_STATUS) ? i_wr.data : RESET_BYTE;
        evt_d = ((evt_q & ~clr_v) | set_v) & 8'h0f;
    end

    // read mux registered so data leaves from flops
    always_comb
    begin
        case (i_rd_addr)
            ADDR_MEAS_STATE: rd_d = {6'h00, wait_q, ready_q};
            ADDR_EVENT_STATUS: rd_d = evt_q;
            ADDR_MEAS_STATUS2: rd_d = {1'b0, valid_q, 1'b0, sat_q, 4'h0};
            ADDR_MUX_STATUS: rd_d = {5'h00, mux_q, 2'b00};
            default: rd_d = RESET_BYTE;
        endcase
    end

    // measurement state, second status and mux done registers
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ready_q <= 1'b0;
            wait_q <= 1'b0;
            valid_q <= 1'b0;
            sat_q <= 1'b0;
            mux_q <= 1'b0;
        end
        else
        begin
            ready_q <= ready_d;
            wait_q <= wait_d;
            valid_q <= valid_d;
            sat_q <= sat_d;
            mux_q <= mux_d;
        end
    end

    // event status register
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            evt_q <= RESET_BYTE;
        else
            evt_q <= evt_d;
    end

    // read data register: a read costs a cycle but the output never glitches
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            rd_q <= RESET_BYTE;
        else
            rd_q <= rd_d;
    end

    assign o_rd_data = rd_q;
    assign o_event_status = evt_q;

    //////////////////////////////////////////////////////////////////////
    // a full clear with nothing arriving must empty the register
    sequence s_clear_all;
        wr_hit(i_wr, ADDR_EVENT_STATUS) && (i_wr.data == 8'hff) && (set_v == 8'h00);
    endsequence

    // the fifo condition still pending on the next edge, as after a host clear
    sequence s_fifo_held;
        i_fifo_irq_enable && fifo_cond ##1 i_fifo_irq_enable && fifo_cond;
    endsequence

    // a mux completion, then the system source enabled while its flag stands
    sequence s_mux_then_enabled;
        i_mux_command_done ##1 i_system_irq_enable;
    endsequence

    // write-one clears, write-zero keeps
    a_w1c_clears: assert property (@(posedge i_clk) disable iff (!i_rstn)
        s_clear_all |=> evt_q == 8'h00)
        else $error("write one did not clear");
    a_w1c_single: assert property (@(posedge i_clk) disable iff (!i_rstn)
        wr_hit(i_wr, ADDR_EVENT_STATUS) && i_wr.data[BIT_CALIB] && !set_v[BIT_CALIB]
        |=> !evt_q[BIT_CALIB])
        else $error("single bit clear missed");
    a_w0_keeps: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (evt_q != 8'h00) && !wr_hit(i_wr, ADDR_EVENT_STATUS)
        |=> (evt_q & $past(evt_q)) == $past(evt_q))
        else $error("flag lost without clear");
    a_w0_in_write: assert property (@(posedge i_clk) disable iff (!i_rstn)
        wr_hit(i_wr, ADDR_EVENT_STATUS)
        |=> ($past(evt_q) & ~$past(i_wr.data) & ~evt_q) == 8'h00)
        else $error("flag lost on write of zero");
    // an event in the clearing cycle wins
    a_set_wins: assert property (@(posedge i_clk) disable iff (!i_rstn)
        set_v[BIT_FIFO] |=> evt_q[BIT_FIFO])
        else $error("fifo event lost");
    a_cal_wins: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_calibration_event |=> evt_q[BIT_CALIB])
        else $error("calibration event lost");
    // event sources
    a_spec_event: assert property (@(posedge i_clk) disable iff (!i_rstn)
        thr_hit && i_spectral_irq_enable |=> evt_q[BIT_SPECTRAL])
        else $error("spectral flag missing");
    a_fifo_refire: assert property (@(posedge i_clk) disable iff (!i_rstn)
        s_fifo_held |=> evt_q[BIT_FIFO])
        else $error("fifo flag not re-raised");
    a_fifo_drained: assert property (@(posedge i_clk) disable iff (!i_rstn)
        wr_hit(i_wr, ADDR_EVENT_STATUS) && i_wr.data[BIT_FIFO] && !fifo_cond
        |=> !evt_q[BIT_FIFO])
        else $error("drained fifo flag not cleared");
    a_sys_event: assert property (@(posedge i_clk) disable iff (!i_rstn)
        s_mux_then_enabled |=> evt_q[BIT_SYSTEM])
        else $error("system flag missing");
    a_mux_done: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_mux_command_done |=> mux_q)
        else $error("mux done flag missing");
    a_mux_clear: assert property (@(posedge i_clk) disable iff (!i_rstn)
        wr_hit(i_wr, ADDR_MUX_STATUS) && i_wr.data[BIT_MUX_DONE] && !i_mux_command_done
        |=> !mux_q)
        else $error("mux done flag not cleared");
    // measurement state and second status
    a_ready_track: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_meas.meas_done |=> ready_q && valid_q)
        else $error("ready or valid missing");
    a_busy_track: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_meas.meas_start && !i_meas.meas_done |=> !ready_q)
        else $error("busy not shown");
    a_wait_sync: assert property (@(posedge i_clk) disable iff (!i_rstn)
        wait_q |-> $past(i_sync_start_mode) || $past(i_sync_start_stop_mode))
        else $error("wait outside sync mode");
    a_wait_follow: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_meas.sync_wait && (i_sync_start_mode || i_sync_start_stop_mode) |=> wait_q)
        else $error("sync wait not shown");
    a_dig_sat: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_meas.peak_count >= i_meas.max_count |=> sat_q)
        else $error("saturation missed");
    a_valid_done: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_meas.meas_done |=> valid_q)
        else $error("valid missing");
endmodule : spectral_status_flags

// File: shared/status_flags_pkg.sv
package status_flags_pkg;
    localparam logic [7:0] ADDR_MEAS_STATE = 8'h71;
    localparam logic [7:0] ADDR_EVENT_STATUS = 8'h93;
    localparam logic [7:0] ADDR_MEAS_STATUS2 = 8'ha3;
    localparam logic [7:0] ADDR_MUX_STATUS = 8'ha6;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int BIT_READY = 0;
    localparam int BIT_WAIT_SYNC = 1;
    localparam int BIT_SYSTEM = 0;
    localparam int BIT_CALIB = 1;
    localparam int BIT_FIFO = 2;
    localparam int BIT_SPECTRAL = 3;
    localparam int BIT_DIG_SAT = 4;
    localparam int BIT_VALID = 6;
    localparam int BIT_MUX_DONE = 2;
    localparam logic [3:0] PERS_RESET = 4'h0;

    // register write strobe carrier
    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_wr_t;

    // measurement progress events from the sequencer
    typedef struct packed {
        logic meas_start;
        logic meas_done;
        logic sync_wait;
        logic [15:0] ch0_result;
        logic [15:0] max_count;
        logic [15:0] peak_count;
    } meas_evt_t;
endpackage : status_flags_pkg

// File: src/threshold_persist.sv
`timescale 1ns/100ps
module threshold_persist
    import status_flags_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_sample,
    input wire logic [15:0] i_ch0,
    input wire logic [15:0] i_th_low,
    input wire logic [15:0] i_th_high,
    input wire logic [3:0] i_persistence_count,
    output logic o_hit
);
    logic [3:0] run_q;
    logic [3:0] run_d;
    logic out_win;
    logic hit_d;

    // count consecutive out-of-window samples; an in-window one restarts it
    always_comb
    begin
        out_win = (i_ch0 < i_th_low) || (i_ch0 > i_th_high);
        run_d = run_q;
        hit_d = 1'b0;
        if (i_sample)
        begin
            if (!out_win)
                run_d = PERS_RESET;
            else
            begin
                if (run_q != 4'hf)
                    run_d = run_q + 4'h1;
                hit_d = (run_q + 4'h1) >= ({1'b0, i_persistence_count} + 4'h1);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            run_q <= PERS_RESET;
            o_hit <= 1'b0;
        end
        else
        begin
            run_q <= run_d;
            o_hit <= hit_d;
        end
    end

    // a hit only ever answers an out-of-window sample one edge earlier
    a_hit_needs_out: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_hit |-> $past(i_sample) && $past(out_win))
        else $error("hit without out-of-window sample");
endmodule : threshold_persist

// File: dv/host_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// host on the register bus; every request moves at a falling edge only
module host_model
    import status_flags_pkg::*;
(
    input wire logic i_clk,
    input wire logic [7:0] i_rd_data,
    output reg_wr_t o_wr,
    output logic [7:0] o_rd_addr
);
    // idle bus: no strobe, read pointed at an unmapped byte
    initial
    begin
        o_wr = '0;
        o_rd_addr = 8'h00;
    end
    // one-cycle write strobe, dropped at the next falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_wr = '{en: 1'b1, addr: a, data: d};
        @(negedge i_clk);
        o_wr = '0;
    endtask : wr
    // read data is registered, so it is taken a full cycle after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk);
        o_rd_addr = a;
        @(negedge i_clk);
        d = i_rd_data;
    endtask : rd
    // write back only what was seen, so a late event keeps its flag
    task automatic service(output logic [7:0] d);
        rd(ADDR_EVENT_STATUS, d);
        wr(ADDR_EVENT_STATUS, d);
    endtask : service
endmodule : host_model

// File: dv/tb_spectral_status_flags.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %0t: got %h expected %h", $time, (g), (e)); end end
module tb_spectral_status_flags;
    import status_flags_pkg::*;
    logic i_clk, i_rstn, sync_start_mode, sync_start_stop_mode, sp_en, ff_en, sys_en, cal, mux;
    reg_wr_t wr;
    logic [7:0] rd_addr, rd_data, ev, fill, seen;
    logic [7:0] reset_addrs [5] = '{ADDR_MEAS_STATE, ADDR_EVENT_STATUS, ADDR_MEAS_STATUS2,
        ADDR_MUX_STATUS, 8'h55};
    meas_evt_t meas;
    int mismatches, n_checks, cycles;
    ////////////////////////////////////////////////////////////////////
    host_model host (.i_clk(i_clk), .i_rd_data(rd_data), .o_wr(wr), .o_rd_addr(rd_addr));
    spectral_status_flags dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_wr(wr),
        .i_rd_addr(rd_addr), .o_rd_data(rd_data), .i_meas(meas),
        .i_sync_start_mode(sync_start_mode), .i_sync_start_stop_mode(sync_start_stop_mode),
        .i_spectral_irq_enable(sp_en), .i_fifo_irq_enable(ff_en),
        .i_system_irq_enable(sys_en), .i_persistence_count(4'h1),
        .i_th_low(16'h0100), .i_th_high(16'h0200), .i_fifo_fill_count(fill),
        .i_fifo_threshold(8'h04), .i_calibration_event(cal),
        .i_mux_command_done(mux), .o_event_status(ev));
    ////////////////////////////////////////////////////////////////////
    // 200 MHz clock
    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            $display("ERROR %0t: timeout", $time);
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    // read a register and compare it
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        `CHK(d, e)
    endtask : rc
    // one-cycle pulse: 0 start, 1 done, 2 calibration, 3 mux done
    task automatic strobe(input int k);
        @(negedge i_clk);
        {meas.meas_start, meas.meas_done, cal, mux} = 4'b1000 >> k;
        @(negedge i_clk);
        {meas.meas_start, meas.meas_done, cal, mux} = 4'h0;
    endtask : strobe
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        i_rstn = 1'b0;
        meas = '0;
        meas.max_count = 16'hffff;
        meas.ch0_result = 16'h0180; // inside the window, persistence stays idle
        {sync_start_mode, sync_start_stop_mode, sp_en, ff_en, sys_en, cal, mux} = '0;
        fill = 8'h00;
        repeat (16) @(negedge i_clk);
        i_rstn = 1'b1;
        foreach (reset_addrs[i])
            rc(reset_addrs[i], 8'h00);
        $display("test reset done");
        // sync wait only counts in the two external-sync modes
        meas.sync_wait = 1'b1;
        for (int m = 0; m < 3; m++)
        begin
            sync_start_mode = (m == 1);
            sync_start_stop_mode = (m == 2);
            rc(ADDR_MEAS_STATE, (m > 0) ? 8'h02 : 8'h00);
        end
        meas.sync_wait = 1'b0;
        rc(ADDR_MEAS_STATE, 8'h00);
        $display("test sync done");
        strobe(0);
        rc(ADDR_MEAS_STATE, 8'h00);
        meas.peak_count = 16'hffff;
        strobe(1);
        rc(ADDR_MEAS_STATE, 8'h01);
        rc(ADDR_MEAS_STATUS2, 8'h50);
        meas.peak_count = 16'h0000;
        strobe(0);
        rc(ADDR_MEAS_STATUS2, 8'h00);
        $display("test measure done");
        // two out-of-window results are needed with persistence one
        sp_en = 1'b1;
        meas.ch0_result = 16'h0300;
        strobe(1);
        repeat (2) @(negedge i_clk);
        rc(ADDR_EVENT_STATUS, 8'h00);
        strobe(1);
        repeat (2) @(negedge i_clk);
        rc(ADDR_EVENT_STATUS, 8'h08);
        $display("test threshold done");
        strobe(3);
        rc(ADDR_MUX_STATUS, 8'h04);
        rc(ADDR_EVENT_STATUS, 8'h08);
        sys_en = 1'b1;
        strobe(2);
        rc(ADDR_EVENT_STATUS, 8'h0b);
        `CHK(ev, 8'h0b)
        host.wr(ADDR_EVENT_STATUS, 8'h00);
        rc(ADDR_EVENT_STATUS, 8'h0b);
        host.wr(ADDR_EVENT_STATUS, 8'h02);
        rc(ADDR_EVENT_STATUS, 8'h09);
        host.wr(ADDR_MUX_STATUS, 8'h04);
        rc(ADDR_MUX_STATUS, 8'h00);
        host.service(seen);
        rc(ADDR_EVENT_STATUS, 8'h00);
        $display("test clear done");
        ff_en = 1'b1;
        fill = 8'h03;
        rc(ADDR_EVENT_STATUS, 8'h00);
        fill = 8'h04;
        rc(ADDR_EVENT_STATUS, 8'h04);
        host.wr(ADDR_EVENT_STATUS, 8'h04);
        rc(ADDR_EVENT_STATUS, 8'h04);
        fill = 8'h00;
        host.wr(ADDR_EVENT_STATUS, 8'h04);
        rc(ADDR_EVENT_STATUS, 8'h00);
        $display("test fifo done");
        // event held high across the clearing edge must win
        cal = 1'b1;
        host.wr(ADDR_EVENT_STATUS, 8'h02);
        cal = 1'b0;
        rc(ADDR_EVENT_STATUS, 8'h02);
        $display("test collide done");
        // low side: an in-window result restarts the count first
        meas.ch0_result = 16'h0180;
        strobe(1);
        meas.ch0_result = 16'h0050;
        strobe(1);
        repeat (2) @(negedge i_clk);
        rc(ADDR_EVENT_STATUS, 8'h02);
        strobe(1);
        repeat (2) @(negedge i_clk);
        rc(ADDR_EVENT_STATUS, 8'h0a);
        $display("test low side done");
        end_of_test();
    end
endmodule : tb_spectral_status_flags
